// ---- hdl/pcd_core.sv ----
// Program counter, return stack, data address decode and R-page registers.
// Assumes the decoder reports each finished instruction by step with its op,
// and that F-page and S-page registers live outside and answer combinationally.
//
// Summary of operation
// - Program counter is ten bits wide.
// - Fetching starts at address zero after reset.
// - Software interrupt jumps to address one.
// - Hardware interrupts jump to shared vector eight.
// - Calls and interrupts push, returns pop stack.
// - Return stack holds eight hardware levels.
// - Short calls reach 256, short jump 512.
// - Indirect: bank from pointer top, location low.
// - Direct: bank from pointer, location from opcode.
// - Low sixteen addresses mirror bank zero registers.
// - General RAM sits once, other banks mirror it.
// - F and S pages ignore bank bits.
// - Indirect port acts on the pointed register.
// - Timer count reads live, writes take effect.
// - Timer counts instruction, pin or slow clock.
// - Low byte increments after each plain instruction.
// - Counter moves only on a finished instruction or low byte write.
// - Buffer low bits hold pending upper bits.
// - Short jump takes buffer bit one on top.
// - Short call takes buffer bits, pushes next.
// - Long jump and call load all ten bits.
`timescale 1ns/100ps
module pcd_core
  import pcd_pkg::*;
#(
  parameter int STACK_DEPTH = pcd_pkg::STACK_LEVELS
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              step,
  input  wire pcd_pkg::pcd_op_t  op,
  input  wire logic [9:0]        instr_word,
  input  wire logic              dat_rd,
  input  wire logic              dat_wr,
  input  wire pcd_pkg::pcd_page_t dat_page,
  input  wire logic [5:0]        dat_addr,
  input  wire logic [7:0]        dat_wdata,
  output logic [7:0]             dat_rdata,
  output logic                   dat_valid,
  output logic                   ext_rd,
  output logic                   ext_wr,
  output logic                   ext_page_s,
  output logic [3:0]             ext_addr,
  output logic [7:0]             ext_wdata,
  input  wire logic [7:0]        ext_rdata,
  input  wire logic              instruction_clock,
  input  wire logic              external_count_clock_pin,
  input  wire logic              low_osc_clock,
  input  wire logic              timer_zero_mode_bits,
  input  wire logic              cfg_low_osc_source,
  output logic [9:0]             pc,
  output logic [7:0]             timer_count
);
  import pcd_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  // Stack pointer arithmetic relies on a power-of-two depth.
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_chk
    $error("STACK_DEPTH must be a power of two of at least 2.");
  end

  // Maps a location in 0x10..0x3f onto the single physical RAM array.
  function automatic logic [5:0] gpr_index(input logic [5:0] loc);
    gpr_index = loc - GPR_FIRST;
  endfunction : gpr_index

  // Reset value of the plain storage registers in the low sixteen locations.
  function automatic logic [7:0] misc_reset(input logic [3:0] idx);
    case ({2'b00, idx})
      ADDR_FLAGS:  misc_reset = RST_FLAGS;
      ADDR_POWER:  misc_reset = RST_POWER;
      ADDR_WAKE:   misc_reset = RST_WAKE;
      ADDR_PULLDN: misc_reset = RST_PULLDN;
      ADDR_PULLUP: misc_reset = RST_PULLUP;
      default:     misc_reset = RST_ZERO;
    endcase
  endfunction : misc_reset

  // True for locations held as plain storage without own behaviour.
  function automatic logic is_plain(input logic [5:0] loc);
    is_plain = (loc == ADDR_FLAGS) || (loc == ADDR_PORT_B) || (loc == ADDR_POWER)
            || (loc == ADDR_WAKE) || (loc == ADDR_PULLDN) || (loc == ADDR_PULLUP)
            || (loc == ADDR_INT_EN) || (loc == ADDR_INT_FLAG);
  endfunction : is_plain

  logic [9:0]      pc_q;
  logic [7:0]      fsp_q;
  logic [2:0]      hbuf_q;
  logic [7:0]      tmr_q;
  logic [7:0]      misc_q [16];
  logic [7:0]      gpr_q [GPR_WORDS];
  logic [9:0]      stk_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [9:0]      stack_top;
  logic [1:0]      bank;
  logic [5:0]      loc;
  logic            r_wr;
  logic            r_rd;
  logic            pcl_wr;
  logic            push;
  logic            pop;
  logic            ext_s1_q, ext_s2_q, ext_s3_q;
  logic            low_s1_q, low_s2_q, low_s3_q;
  logic            tmr_tick;
  logic [7:0]      r_data;

  // Address decode; the bank is formed in both modes but every bank mirrors bank 0.
  // indirect location
  always_comb begin
    bank = fsp_q[BANK_HI:BANK_LO];
    loc  = (dat_addr == ADDR_INDIRECT) ? fsp_q[5:0] : dat_addr;
  end

  // RAM mirroring
  // Strobes for R-page accesses; the bank bits take no part in the decode.
  assign r_wr   = dat_wr && (dat_page == PAGE_R) && (loc != ADDR_INDIRECT);
  assign r_rd   = dat_rd && (dat_page == PAGE_R);
  assign pcl_wr = r_wr && (loc == ADDR_PC_LOW);
  assign stack_top = stk_q[sp_q - SP_W'(1)];

  // push and pop
  // A written low byte overrides the decoder's op for that cycle.
  assign push = step && !pcl_wr && (op == OP_SHORT_CALL || op == OP_PAGE_CALL
             || op == OP_LONG_CALL || op == OP_SOFT_INT || op == OP_HW_INT);
  assign pop  = step && !pcl_wr && (op == OP_RETURN);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc_q <= VEC_RESET;
    end else if (pcl_wr) begin
      pc_q <= {hbuf_q[1:0], dat_wdata};
    end else if (step) begin
      case (op)
        OP_NEXT:       pc_q <= pc_q + 10'h001;
        OP_SHORT_JUMP: pc_q <= {hbuf_q[1], instr_word[8:0]};
        OP_SHORT_CALL,
        OP_PAGE_JUMP,
        OP_PAGE_CALL:  pc_q <= {hbuf_q[1:0], instr_word[7:0]};
        OP_LONG_JUMP,
        OP_LONG_CALL:  pc_q <= instr_word;
        OP_RETURN:     pc_q <= stack_top;
        OP_SOFT_INT:   pc_q <= VEC_SOFT;
        OP_HW_INT:     pc_q <= VEC_HW;
        default:       pc_q <= pc_q + 10'h001;
      endcase
    end
  end

  // circular overwrite
  // The pointer simply wraps; overflow and underflow are not reported.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_q[i] <= VEC_RESET;
      end
    end else if (push) begin
      stk_q[sp_q] <= pc_q + 10'h001;
      sp_q        <= sp_q + SP_W'(1);
    end else if (pop) begin
      sp_q <= sp_q - SP_W'(1);
    end
  end

  // pending upper bits
  // Pointer and high buffer registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fsp_q  <= RST_FSP;
      hbuf_q <= RST_PC_HIGH[2:0];
    end else if (r_wr && loc == ADDR_FSP) begin
      fsp_q <= dat_wdata;
    end else if (r_wr && loc == ADDR_PC_HIGH) begin
      hbuf_q <= dat_wdata[HBUF_GP:0];
    end
  end

  // Plain storage for the remaining low registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 16; i++) begin
        misc_q[i] <= misc_reset(4'(i));
      end
    end else if (r_wr && is_plain(loc)) begin
      misc_q[loc[3:0]] <= dat_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (r_wr && loc >= GPR_FIRST) begin
      gpr_q[gpr_index(loc)] <= dat_wdata;
    end
  end

  // Two-stage synchronisers with a third stage for edge detection.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {ext_s1_q, ext_s2_q, ext_s3_q} <= 3'h0;
      {low_s1_q, low_s2_q, low_s3_q} <= 3'h0;
    end else begin
      {ext_s1_q, ext_s2_q, ext_s3_q} <= {external_count_clock_pin, ext_s1_q, ext_s2_q};
      {low_s1_q, low_s2_q, low_s3_q} <= {low_osc_clock, low_s1_q, low_s2_q};
    end
  end

  always_comb begin
    if (!timer_zero_mode_bits) begin
      tmr_tick = instruction_clock;
    end else if (cfg_low_osc_source) begin
      tmr_tick = low_s2_q && !low_s3_q;
    end else begin
      tmr_tick = ext_s2_q && !ext_s3_q;
    end
  end

  // live timer count
  // A software write wins over a count in the same cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tmr_q <= RST_TIMER;
    end else if (r_wr && loc == ADDR_TIMER) begin
      tmr_q <= dat_wdata;
    end else if (tmr_tick) begin
      tmr_q <= tmr_q + 8'h01;
    end
  end

  // Read multiplexer for the R page; reserved and self-pointing reads give zero.
  always_comb begin
    r_data = RST_ZERO;
    if (loc >= GPR_FIRST) begin
      r_data = gpr_q[gpr_index(loc)];
    end else if (loc == ADDR_TIMER) begin
      r_data = tmr_q;
    end else if (loc == ADDR_PC_LOW) begin
      r_data = pc_q[7:0];
    end else if (loc == ADDR_FSP) begin
      r_data = fsp_q;
    end else if (loc == ADDR_PC_HIGH) begin
      r_data = {5'h00, hbuf_q};
    end else if (is_plain(loc)) begin
      r_data = misc_q[loc[3:0]];
    end
  end

  // F and S page port
  // Only four location bits go out, so the bank bits cannot reach these pages.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_rd     <= 1'b0;
      ext_wr     <= 1'b0;
      ext_page_s <= 1'b0;
      ext_addr   <= 4'h0;
      ext_wdata  <= 8'h00;
    end else begin
      ext_rd     <= dat_rd && (dat_page != PAGE_R);
      ext_wr     <= dat_wr && (dat_page != PAGE_R);
      ext_page_s <= (dat_page == PAGE_S);
      ext_addr   <= dat_addr[3:0];
      ext_wdata  <= dat_wdata;
    end
  end

  // Read data: R page one cycle after the request, F and S pages two cycles.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dat_rdata <= 8'h00;
      dat_valid <= 1'b0;
    end else if (r_rd) begin
      dat_rdata <= r_data;
      dat_valid <= 1'b1;
    end else if (ext_rd) begin
      dat_rdata <= ext_rdata;
      dat_valid <= 1'b1;
    end else begin
      dat_valid <= 1'b0;
    end
  end

  assign pc          = pc_q;
  assign timer_count = tmr_q;

  // Checks on counter sequencing, stack and registers.
  a_reset_vector: assert property (@(posedge clock) disable iff (!rstn)
    !$past(rstn) |-> pc_q == VEC_RESET)
    else $error("Counter not at reset vector after reset.");

  a_soft_vector: assert property (@(posedge clock) disable iff (!rstn)
    step && !pcl_wr && op == OP_SOFT_INT |=> pc_q == 10'h001)
    else $error("Software interrupt did not reach vector one.");

  a_hw_vector: assert property (@(posedge clock) disable iff (!rstn)
    step && !pcl_wr && op == OP_HW_INT |=> pc_q == 10'h008)
    else $error("Hardware interrupt did not reach vector eight.");

  a_call_return_pair: assert property (@(posedge clock) disable iff (!rstn)
    step && !pcl_wr && op == OP_LONG_CALL ##1 step && !pcl_wr && op == OP_RETURN
    |=> pc_q == $past(pc_q, 2) + 10'h001)
    else $error("Return after call did not resume after the call.");

  a_stack_wrap: assert property (@(posedge clock) disable iff (!rstn)
    push |=> sp_q == $past(sp_q) + SP_W'(1))
    else $error("Stack pointer did not advance on push.");

  a_short_jump: assert property (@(posedge clock) disable iff (!rstn)
    step && !pcl_wr && op == OP_SHORT_JUMP
    |=> pc_q == {$past(hbuf_q[1]), $past(instr_word[8:0])})
    else $error("Short jump target wrong.");

  a_short_call: assert property (@(posedge clock) disable iff (!rstn)
    step && !pcl_wr && op == OP_SHORT_CALL
    |=> pc_q == {$past(hbuf_q[1:0]), $past(instr_word[7:0])}
        && stack_top == $past(pc_q) + 10'h001)
    else $error("Short call target or pushed address wrong.");

  a_long_jump: assert property (@(posedge clock) disable iff (!rstn)
    step && !pcl_wr && op == OP_LONG_JUMP |=> pc_q == $past(instr_word))
    else $error("Long jump target wrong.");

  a_pc_increment: assert property (@(posedge clock) disable iff (!rstn)
    step && !pcl_wr && op == OP_NEXT |=> pc_q == $past(pc_q) + 10'h001)
    else $error("Counter did not increment by one.");

  a_upper_hold: assert property (@(posedge clock) disable iff (!rstn)
    !step && !pcl_wr |=> pc_q == $past(pc_q))
    else $error("Counter moved without an instruction or write.");

  a_timer_write: assert property (@(posedge clock) disable iff (!rstn)
    r_wr && loc == ADDR_TIMER |=> tmr_q == $past(dat_wdata))
    else $error("Timer write did not take effect.");

  a_indirect_read: assert property (@(posedge clock) disable iff (!rstn)
    r_rd && dat_addr == ADDR_INDIRECT && fsp_q[5:0] == ADDR_FSP
    |=> dat_valid && dat_rdata == $past(fsp_q))
    else $error("Indirect read did not follow the pointer.");

endmodule : pcd_core

// ---- hdl/pcd_pkg.sv ----
// Constants for the program counter and data address map block.
// Assumes a single core clock and an instruction decoder outside this block.
package pcd_pkg;

  // Program counter width and fixed vectors.
  localparam int          PC_W      = 10;
  localparam logic [9:0]  VEC_RESET = 10'h000;
  localparam logic [9:0]  VEC_SOFT  = 10'h001;
  localparam logic [9:0]  VEC_HW    = 10'h008;
  localparam int          STACK_LEVELS = 8;

  // Data page register offsets within a bank.
  localparam logic [5:0]  ADDR_INDIRECT = 6'h00;
  localparam logic [5:0]  ADDR_TIMER    = 6'h01;
  localparam logic [5:0]  ADDR_PC_LOW   = 6'h02;
  localparam logic [5:0]  ADDR_FLAGS    = 6'h03;
  localparam logic [5:0]  ADDR_FSP      = 6'h04;
  localparam logic [5:0]  ADDR_PORT_B   = 6'h06;
  localparam logic [5:0]  ADDR_POWER    = 6'h08;
  localparam logic [5:0]  ADDR_WAKE     = 6'h09;
  localparam logic [5:0]  ADDR_PC_HIGH  = 6'h0a;
  localparam logic [5:0]  ADDR_PULLDN   = 6'h0b;
  localparam logic [5:0]  ADDR_PULLUP   = 6'h0c;
  localparam logic [5:0]  ADDR_INT_EN   = 6'h0e;
  localparam logic [5:0]  ADDR_INT_FLAG = 6'h0f;
  localparam logic [5:0]  GPR_FIRST     = 6'h10;
  localparam int          GPR_WORDS     = 48;

  // Field positions.
  localparam int          BANK_HI = 7;
  localparam int          BANK_LO = 6;
  localparam int          HBUF_GP = 2;

  // Reset values.
  localparam logic [7:0]  RST_PC_LOW  = 8'h00;
  localparam logic [7:0]  RST_FLAGS   = 8'h18;
  localparam logic [7:0]  RST_FSP     = 8'h00;
  localparam logic [7:0]  RST_PC_HIGH = 8'h00;
  localparam logic [7:0]  RST_TIMER   = 8'h00;
  localparam logic [7:0]  RST_POWER   = 8'h88;
  localparam logic [7:0]  RST_WAKE    = 8'h3f;
  localparam logic [7:0]  RST_PULLDN  = 8'hf0;
  localparam logic [7:0]  RST_PULLUP  = 8'h3f;
  localparam logic [7:0]  RST_ZERO    = 8'h00;

  // Program counter operation reported by the decoder when an instruction ends.
  typedef enum logic [3:0] {
    OP_NEXT       = 4'h0,
    OP_SHORT_JUMP = 4'h1,
    OP_SHORT_CALL = 4'h2,
    OP_PAGE_JUMP  = 4'h3,
    OP_PAGE_CALL  = 4'h4,
    OP_LONG_JUMP  = 4'h5,
    OP_LONG_CALL  = 4'h6,
    OP_RETURN     = 4'h7,
    OP_SOFT_INT   = 4'h8,
    OP_HW_INT     = 4'h9
  } pcd_op_t;

  // Data page selected by the instruction class.
  typedef enum logic [1:0] {
    PAGE_R = 2'h0,
    PAGE_F = 2'h1,
    PAGE_S = 2'h2
  } pcd_page_t;

endpackage : pcd_pkg

// ---- verification/program_counter_and_data_address_map_bench.sv ----
// Self-checking bench for the program counter and data address map core.
// Assumes the core of hdl/pcd_core.sv and the constants of pcd_pkg.
`timescale 1ns/100ps
module program_counter_and_data_address_map_bench;
  import pcd_pkg::*;
  logic            clock;
  logic            rstn;
  logic            step;
  pcd_op_t         op;
  logic [9:0]      instr_word;
  logic            dat_rd;
  logic            dat_wr;
  pcd_page_t       dat_page;
  logic [5:0]      dat_addr;
  logic [7:0]      dat_wdata;
  logic [7:0]      dat_rdata;
  logic            dat_valid;
  logic            ext_rd;
  logic            ext_wr;
  logic            ext_page_s;
  logic [3:0]      ext_addr;
  logic [7:0]      ext_wdata;
  logic [7:0]      ext_rdata;
  logic            instruction_clock;
  logic            external_count_clock_pin;
  logic            low_osc_clock;
  logic            timer_zero_mode_bits;
  logic            cfg_low_osc_source;
  logic [9:0]      pc;
  logic [7:0]      timer_count;
  int              n_mismatch;
  int              check_count;
  int              cycles;
  logic [7:0]      v;

  pcd_core dut (.clock(clock), .rstn(rstn), .step(step), .op(op), .instr_word(instr_word),
    .dat_rd(dat_rd), .dat_wr(dat_wr), .dat_page(dat_page), .dat_addr(dat_addr),
    .dat_wdata(dat_wdata), .dat_rdata(dat_rdata), .dat_valid(dat_valid), .ext_rd(ext_rd),
    .ext_wr(ext_wr), .ext_page_s(ext_page_s), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata), .instruction_clock(instruction_clock),
    .external_count_clock_pin(external_count_clock_pin), .low_osc_clock(low_osc_clock),
    .timer_zero_mode_bits(timer_zero_mode_bits), .cfg_low_osc_source(cfg_low_osc_source),
    .pc(pc), .timer_count(timer_count));

  // Free-running core clock of 10 ns.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Prints the verdict once and ends the run.
  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // Compares one value and counts the result.
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask : chk

  // Issues one finished instruction and checks the new fetch address.
  task automatic stp(input pcd_op_t o, input logic [9:0] w, input logic [9:0] exp);
    @(posedge clock);
    step <= 1'b1;
    op <= o;
    instr_word <= w;
    @(posedge clock);
    step <= 1'b0;
    #1 chk("pc", pc, exp);
  endtask : stp

  // Data write; for F and S pages the outgoing strobe is checked too.
  task automatic dwr(input pcd_page_t pg, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    dat_wr <= 1'b1;
    dat_page <= pg;
    dat_addr <= a;
    dat_wdata <= d;
    @(posedge clock);
    dat_wr <= 1'b0;
    #1;
    if (pg != PAGE_R) begin
      chk("ext_wr", ext_wr, 1'b1);
      chk("ext_addr", ext_addr, a[3:0]);
      chk("ext_page_s", ext_page_s, pg == PAGE_S);
      chk("ext_wdata", ext_wdata, d);
    end
  endtask : dwr

  // Data read returning the captured value.
  task automatic drd(input pcd_page_t pg, input logic [5:0] a, output logic [7:0] r);
    @(posedge clock);
    dat_rd <= 1'b1;
    dat_page <= pg;
    dat_addr <= a;
    @(posedge clock);
    dat_rd <= 1'b0;
    #1;
    if (pg != PAGE_R) begin
      chk("ext_rd", ext_rd, 1'b1);
      chk("ext_addr", ext_addr, a[3:0]);
      chk("ext_page_s", ext_page_s, pg == PAGE_S);
      @(posedge clock);
      #1;
    end
    chk("dat_valid", dat_valid, 1'b1);
    r = dat_rdata;
  endtask : drd

  task automatic t_data();
    drd(PAGE_R, 6'h03, v);
    chk("flags reset", v, RST_FLAGS);
    drd(PAGE_R, 6'h08, v);
    chk("power reset", v, 8'h88);
    dwr(PAGE_R, 6'h05, 8'hff);
    drd(PAGE_R, 6'h05, v);
    chk("reserved", v, 8'h00);
    dwr(PAGE_R, 6'h04, 8'hd0);
    dwr(PAGE_R, 6'h10, 8'h3c);
    drd(PAGE_R, 6'h00, v);
    chk("indirect read", v, 8'h3c);
    dwr(PAGE_R, 6'h00, 8'h81);
    drd(PAGE_R, 6'h10, v);
    chk("direct read", v, 8'h81);
    drd(PAGE_R, 6'h04, v);
    chk("pointer", v, 8'hd0);
    dwr(PAGE_R, 6'h04, 8'hc4);
    drd(PAGE_R, 6'h00, v);
    chk("indirect self", v, 8'hc4);
  endtask : t_data

  task automatic t_pc();
    stp(OP_NEXT, 10'h000, 10'h001);
    dwr(PAGE_R, 6'h0a, 8'h07);
    drd(PAGE_R, 6'h0a, v);
    chk("high buffer", v, 8'h07);
    stp(OP_SHORT_JUMP, 10'h1ab, 10'h3ab);
    stp(OP_SHORT_CALL, 10'h055, 10'h355);
    stp(OP_RETURN, 10'h000, 10'h3ac);
    stp(OP_PAGE_JUMP, 10'h012, 10'h312);
    stp(OP_PAGE_CALL, 10'h034, 10'h334);
    stp(OP_RETURN, 10'h000, 10'h313);
    dwr(PAGE_R, 6'h02, 8'h77);
    chk("pc low write", pc, 10'h377);
    stp(OP_SOFT_INT, 10'h000, 10'h001);
    stp(OP_RETURN, 10'h000, 10'h378);
    stp(OP_HW_INT, 10'h000, 10'h008);
    stp(OP_RETURN, 10'h000, 10'h379);
  endtask : t_pc

  task automatic t_stack();
    for (int i = 0; i < 9; i++) begin
      stp(OP_LONG_CALL, 10'h100 + 10'(i), 10'h100 + 10'(i));
    end
    for (int j = 1; j <= 9; j++) begin
      stp(OP_RETURN, 10'h000, (j == 9) ? 10'h108 : 10'h109 - 10'(j));
    end
  endtask : t_stack

  // long jump, then a call and a return on consecutive cycles.
  task automatic t_pair();
    stp(OP_LONG_JUMP, 10'h200, 10'h200);
    @(posedge clock);
    step <= 1'b1;
    op <= OP_LONG_CALL;
    instr_word <= 10'h2c0;
    @(posedge clock);
    op <= OP_RETURN;
    #1 chk("pc call", pc, 10'h2c0);
    @(posedge clock);
    step <= 1'b0;
    #1 chk("pc return", pc, 10'h201);
  endtask : t_pair

  task automatic t_timer();
    dwr(PAGE_R, 6'h01, 8'h10);
    chk("timer write", timer_count, 8'h10);
    repeat (3) begin
      @(posedge clock);
      instruction_clock <= 1'b1;
      @(posedge clock);
      instruction_clock <= 1'b0;
    end
    #1 chk("timer ticks", timer_count, 8'h13);
    drd(PAGE_R, 6'h01, v);
    chk("timer read", v, 8'h13);
    timer_zero_mode_bits <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      repeat (3) @(posedge clock);
      if (k < 4) external_count_clock_pin <= ~external_count_clock_pin;
      else low_osc_clock <= ~low_osc_clock;
      if (k == 3) cfg_low_osc_source <= 1'b1;
    end
    repeat (6) @(posedge clock);
    #1 chk("timer edges", timer_count, 8'h17);
  endtask : t_timer

  // F and S pages leave through the outside strobes.
  task automatic t_ext();
    dwr(PAGE_F, 6'h26, 8'h99);
    drd(PAGE_S, 6'h0f, v);
    chk("s page read", v, 8'h5a);
    ext_rdata <= 8'ha5;
    drd(PAGE_F, 6'h0c, v);
    chk("f page read", v, 8'ha5);
  endtask : t_ext

  // Cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // Main sequence: reset, then every scenario in turn.
  initial begin
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    rstn = 1'b0;
    step = 1'b0;
    op = OP_NEXT;
    instr_word = 10'h000;
    dat_rd = 1'b0;
    dat_wr = 1'b0;
    dat_page = PAGE_R;
    dat_addr = 6'h00;
    dat_wdata = 8'h00;
    ext_rdata = 8'h5a;
    instruction_clock = 1'b0;
    external_count_clock_pin = 1'b0;
    low_osc_clock = 1'b0;
    timer_zero_mode_bits = 1'b0;
    cfg_low_osc_source = 1'b0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    #1 chk("pc reset", pc, VEC_RESET);
    chk("timer reset", timer_count, 8'h00);
    t_data();
    t_pc();
    t_stack();
    t_pair();
    t_ext();
    t_timer();
    end_of_test();
  end
endmodule : program_counter_and_data_address_map_bench
